// >>> moe_pkg.sv
// package for the move/or execution datapath
package moe_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int WORD_W = 14;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7f;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;
  localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;
  // instruction word field positions
  localparam int DEST_BIT = 7;
  localparam int ADDR_LSB = 0;
  localparam int LIT_LSB = 0;
  // opcode encodings, upper bits of the 14-bit word
  localparam logic [5:0] OP_OR_ACC_INTO_REG = 6'h04;
  localparam logic [5:0] OP_COPY_REG = 6'h08;
  localparam logic [6:0] OP_STORE_ACC = 7'h01;
  localparam logic [3:0] OP_LOAD_LITERAL = 4'hc;
  localparam logic [WORD_W-1:0] OP_IDLE_INSTRUCTION = 14'h0000;
  typedef enum logic [2:0] {
    MOE_OP_IDLE,
    MOE_OP_OR,
    MOE_OP_COPY,
    MOE_OP_STORE,
    MOE_OP_LOAD,
    MOE_OP_OTHER
  } moe_op_t;
endpackage : moe_pkg

// >>> moe_decode.sv
// instruction word decoder for the move/or datapath
`timescale 1ns/100ps
module moe_decode
  import moe_pkg::*;
(
  // instruction word in
  input wire logic [WORD_W-1:0] instr,
  // decoded fields out
  output moe_op_t op,
  output logic dest,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] literal
);
  // opcode field widths, each field ends at the top bit of the word
  localparam int OR_W = $bits(OP_OR_ACC_INTO_REG);
  localparam int COPY_W = $bits(OP_COPY_REG);
  localparam int STORE_W = $bits(OP_STORE_ACC);
  localparam int LOAD_W = $bits(OP_LOAD_LITERAL);
  // pick out operation and fields
  always_comb begin
    dest = instr[DEST_BIT];
    addr = instr[ADDR_LSB +: ADDR_W];
    literal = instr[LIT_LSB +: DATA_W];
    if (instr == OP_IDLE_INSTRUCTION) begin
      op = MOE_OP_IDLE;
    end else if (instr[WORD_W-1 -: OR_W] == OP_OR_ACC_INTO_REG) begin
      op = MOE_OP_OR;
    end else if (instr[WORD_W-1 -: COPY_W] == OP_COPY_REG) begin
      op = MOE_OP_COPY;
    end else if (instr[WORD_W-1 -: STORE_W] == OP_STORE_ACC) begin
      op = MOE_OP_STORE;
    end else if (instr[WORD_W-1 -: LOAD_W] == OP_LOAD_LITERAL) begin
      op = MOE_OP_LOAD; // low two don't-care bits ignored
    end else begin
      op = MOE_OP_OTHER;
    end
  end
endmodule : moe_decode

// >>> moe_exec.sv
// execution datapath for or, copy, store, load-literal and idle
`timescale 1ns/100ps
// What this block does
// - OR accumulator with register, set zero flag
// - destination bit picks accumulator or register
// - copy register to accumulator or itself
// - copy updates zero flag, even writing back
// - store accumulator to register, flags unchanged
// - load literal into accumulator, flags unchanged
module moe_exec
  import moe_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // instruction word into the decoder, one per cycle while valid
  input wire logic instr_valid,
  input wire logic [WORD_W-1:0] instr,
  // register file read port (combinational on addr)
  output logic [ADDR_W-1:0] rf_addr,
  input wire logic [DATA_W-1:0] rf_rdata,
  // register file write port
  output logic rf_we,
  output logic [ADDR_W-1:0] rf_waddr,
  output logic [DATA_W-1:0] rf_wdata,
  // architectural state
  output logic [DATA_W-1:0] acc,
  output logic zero_flag
);
  // decoded instruction fields
  moe_op_t op;
  logic dest;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] literal;

  // execute strobe and one strobe per class
  logic exec_go;
  logic is_or;
  logic is_copy;
  logic is_store;
  logic is_load;

  // what the executing instruction updates
  logic upd_acc;
  logic upd_zero;
  logic upd_reg;

  // operand path with write forwarding
  logic fwd_hit;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result;
  logic result_zero;

  // accumulator state
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] acc_d;

  // zero flag state
  logic zero_q;
  logic zero_d;

  // register file write port state
  logic we_q;
  logic we_d;
  logic [ADDR_W-1:0] waddr_q;
  logic [ADDR_W-1:0] waddr_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;

  // instruction decoder; unknown words decode as other
  // and execute as nothing
  moe_decode u_decode (
    .instr(instr),
    .op(op),
    .dest(dest),
    .addr(addr),
    .literal(literal)
  );

  // operand address goes straight to the register file
  assign rf_addr = addr;

  // an instruction executes only on an enabled, valid edge;
  // with the enable low nothing is taken and nothing changes
  assign exec_go = clk_en & instr_valid;

  // one strobe per instruction class
  always_comb begin
    is_or = 1'b0;
    is_copy = 1'b0;
    is_store = 1'b0;
    is_load = 1'b0;
    case (op)
      MOE_OP_OR: begin
        is_or = exec_go;
      end
      MOE_OP_COPY: begin
        is_copy = exec_go;
      end
      MOE_OP_STORE: begin
        is_store = exec_go;
      end
      MOE_OP_LOAD: begin
        is_load = exec_go;
      end
      default: begin
        // idle and foreign words raise no strobe
      end
    endcase
  end

  // destination bit steers or and copy results
  always_comb begin
    upd_acc = 1'b0;
    upd_zero = 1'b0;
    upd_reg = 1'b0;
    if (is_or || is_copy) begin
      upd_zero = 1'b1;
      if (dest == DEST_ACC) begin
        upd_acc = 1'b1;
      end else begin
        upd_reg = 1'b1;
      end
    end else if (is_store) begin
      upd_reg = 1'b1;
    end else if (is_load) begin
      upd_acc = 1'b1;
    end
  end

  // the write port is registered, so a write launched by one instruction
  // reaches the file only at the next enabled edge; an instruction that
  // reads the same register at that edge would see the old contents, so
  // the pending value is forwarded instead
  assign fwd_hit = we_q && (waddr_q == addr);
  assign operand = fwd_hit ? wdata_q : rf_rdata;

  // value produced by the executing instruction
  always_comb begin
    result = acc_q;
    if (is_or) begin
      result = acc_q | operand;
    end else if (is_copy) begin
      result = operand;
    end else if (is_store) begin
      result = acc_q;
    end else if (is_load) begin
      result = literal;
    end
  end

  // zero test on the produced value
  assign result_zero = (result == ZERO_VAL);

  // accumulator next value
  always_comb begin
    acc_d = acc_q;
    if (upd_acc) begin
      acc_d = result;
    end
  end

  // accumulator register, frozen while the enable is low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_q <= ACC_RST;
    end else if (clk_en) begin
      acc_q <= acc_d;
    end
  end

  // zero flag next value; store and load leave it alone
  always_comb begin
    zero_d = zero_q;
    if (upd_zero) begin
      zero_d = result_zero;
    end
  end

  // zero flag register, frozen while the enable is low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zero_q <= ZERO_RST;
    end else if (clk_en) begin
      zero_q <= zero_d;
    end
  end

  // write port next values; address and data hold between writes
  // a write-back targets the register that was read
  always_comb begin
    we_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    if (upd_reg) begin
      we_d = 1'b1;
      waddr_d = addr;
      wdata_d = result;
    end
  end

  // write port registers, frozen while the enable is low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      we_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
    end else if (clk_en) begin
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  // state outputs straight from their registers
  assign acc = acc_q;
  assign zero_flag = zero_q;

  // a held write stays pending while the enable is low and is
  // masked so that it lands exactly once, on the next enabled edge
  assign rf_we = we_q & clk_en;
  assign rf_waddr = waddr_q;
  assign rf_wdata = wdata_q;
endmodule : moe_exec

// >>> moe_rf_model.sv
// register file partner of the execution datapath
`timescale 1ns/100ps
module moe_rf_model
  import moe_pkg::*;
(
  // clock and ports
  input wire logic clk_sys,
  input wire logic [ADDR_W-1:0] rf_addr,
  output logic [DATA_W-1:0] rf_rdata,
  input wire logic rf_we,
  input wire logic [ADDR_W-1:0] rf_waddr,
  input wire logic [DATA_W-1:0] rf_wdata
);
  logic [DATA_W-1:0] mem [128];
  // read at once, write at the edge
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  assign rf_rdata = mem[rf_addr];
  always @(posedge clk_sys) if (rf_we) mem[rf_waddr] <= rf_wdata;
endmodule : moe_rf_model

// >>> moe_exec_monitor.sv
// port assertions of the execution datapath
`timescale 1ns/100ps
module moe_exec_monitor
  import moe_pkg::*;
(
  // clock, reset, request
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [WORD_W-1:0] instr,
  // register file and state
  input wire logic [DATA_W-1:0] rf_rdata,
  input wire logic rf_we,
  input wire logic [ADDR_W-1:0] rf_waddr,
  input wire logic [DATA_W-1:0] rf_wdata,
  input wire logic [DATA_W-1:0] acc,
  input wire logic zero_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // accepted request classes
  wire g = clk_en & instr_valid;
  wire o = g && instr[13:8] == OP_OR_ACC_INTO_REG;
  wire c = g && instr[13:8] == OP_COPY_REG;
  wire s = g && instr[13:7] == OP_STORE_ACC;
  wire l = g && instr[13:10] == OP_LOAD_LITERAL;
  // operand as executed: a pending write is newer than the file
  wire [DATA_W-1:0] f = (rf_we && rf_waddr == instr[6:0]) ? rf_wdata :
    rf_rdata;
  a_or_acc: assert property (o && !instr[7] |=>
    acc == ($past(acc) | $past(f)) && zero_flag == (acc == 0))
    else $error("or to acc wrong");
  a_or_back: assert property (o && instr[7] |=> rf_we == clk_en &&
    rf_wdata == ($past(acc) | $past(f)) && $stable(acc) &&
    rf_waddr == $past(instr[6:0])) else $error("or write back wrong");
  a_copy_acc: assert property (c && !instr[7] |=>
    acc == $past(f) && !rf_we) else $error("copy wrong");
  a_copy_back: assert property (c && instr[7] |=> rf_we == clk_en &&
    rf_wdata == $past(f) && rf_waddr == $past(instr[6:0]) && $stable(acc))
    else $error("copy write back wrong");
  a_copy_zero: assert property (c |=>
    zero_flag == ($past(f) == 0)) else $error("copy zero wrong");
  a_store_reg: assert property (s |=> rf_we == clk_en &&
    rf_wdata == $past(acc) && rf_waddr == $past(instr[6:0]) &&
    $stable(zero_flag)) else $error("store wrong");
  a_load_lit: assert property (l |=>
    acc == $past(instr[7:0]) && $stable(zero_flag)) else $error("load wrong");
  a_idle_none: assert property (g && instr == 0 |=> !rf_we &&
    $stable(acc) && $stable(zero_flag)) else $error("idle changed state");
endmodule : moe_exec_monitor
bind moe_exec moe_exec_monitor u_mon (.clk_sys(clk_sys), .rst(rst),
  .clk_en(clk_en), .instr_valid(instr_valid), .instr(instr),
  .rf_rdata(rf_rdata), .rf_we(rf_we), .rf_waddr(rf_waddr),
  .rf_wdata(rf_wdata), .acc(acc), .zero_flag(zero_flag));

// >>> tb.sv
// self-checking bench of the execution datapath
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb;
  import moe_pkg::*;
  logic clk_sys = 0, rst = 1, clk_en = 0, instr_valid = 0;
  logic [WORD_W-1:0] instr = '0;
  logic [ADDR_W-1:0] rf_addr, rf_waddr, m_wa;
  logic [DATA_W-1:0] rf_rdata, rf_wdata, acc, m_acc = 0, m_wd, v, mem [128];
  logic rf_we, zero_flag, m_z = 0, m_we = 0;
  int errors = 0, total_checks = 0;
  logic [31:0] lf = 32'ha983;
  moe_exec DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr(instr), .rf_addr(rf_addr),
    .rf_rdata(rf_rdata), .rf_we(rf_we), .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata), .acc(acc), .zero_flag(zero_flag));
  moe_rf_model RF (.clk_sys(clk_sys), .rf_addr(rf_addr),
    .rf_rdata(rf_rdata), .rf_we(rf_we), .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata));
  // random word per class, with corner cases in classes 6 and 7
  function logic [WORD_W-1:0] mk(logic [2:0] s, logic [7:0] r);
    case (s)
      0: return {OP_OR_ACC_INTO_REG, r};
      1: return {OP_COPY_REG, r};
      2: return {OP_STORE_ACC, r[6:0]};
      3: return {OP_LOAD_LITERAL, 2'b00, r};
      4: return OP_IDLE_INSTRUCTION;
      5: return 14'h3fff;
      6: return {OP_COPY_REG, 8'h80};
      default: return {OP_LOAD_LITERAL, 10'h000};
    endcase
  endfunction : mk
  // next state of the stimulus shift register
  function logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // value an instruction produces from accumulator a and operand f
  function logic [DATA_W-1:0] exp_val(logic [WORD_W-1:0] w,
    logic [DATA_W-1:0] a, logic [DATA_W-1:0] f);
    casez (w)
      14'b000100????????: return a | f;
      14'b001000????????: return f;
      14'b1100??????????: return w[7:0];
      default: return a;
    endcase
  endfunction : exp_val
  task conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial forever #10 clk_sys = ~clk_sys;
  initial begin
    #20000 errors++;
    conclude();
  end
  // drive at falling edge, check the previous instruction's effect
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
    repeat (16) @(negedge clk_sys);
    rst = 0;
    repeat (400) begin
      @(negedge clk_sys);
      `CHK("acc", m_acc, acc)
      `CHK("zero", m_z, zero_flag)
      `CHK("we", m_we, rf_we)
      `CHK("raddr", instr[ADDR_W-1:0], rf_addr)
      if (m_we) `CHK("wr", {m_wa, m_wd}, {rf_waddr, rf_wdata})
      lf = lfsr(lf);
      clk_en = lf[8] | lf[9];
      instr_valid = lf[10] | lf[11];
      instr = mk(lf[2:0], lf[23:16]);
      v = exp_val(instr, m_acc, mem[instr[6:0]]);
      m_wa = instr[6:0];
      m_we = 0;
      if (clk_en && instr_valid) casez (instr)
        14'b000100????????, 14'b001000????????: begin
          m_z = v == 0;
          if (instr[7]) m_we = 1;
          else m_acc = v;
        end
        14'b0000001???????: m_we = 1;
        14'b1100??????????: m_acc = v;
        default: ;
      endcase
      m_wd = v;
      if (m_we) mem[m_wa] = v;
    end
    $display("test random_mix done");
    conclude();
  end
endmodule : tb
